// file: logic/dsc_edge_cap.v
// one strobe group: strobe sync, phase-shift delay, two-edge capture
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.vh"

module dsc_edge_cap #(
  parameter DQ_W  = 8,
  parameter CNT_W = 8
) (
  // clock and reset
  input  wire              sys_clk,
  input  wire              resetn,
  // pins, raw
  input  wire              dqs_pin,
  input  wire [DQ_W-1:0]   dq_pin,
  // control, already synchronous
  input  wire              listen,
  input  wire              fcram_mode,
  // captured pair
  output reg               pair_valid_r,
  output reg  [2*DQ_W-1:0] pair_data_r
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  reg            dqs_s1_r;
  reg            dqs_s2_r;
  reg            dqs_s3_r;
  reg [DQ_W-1:0] dq_s1_r;
  reg [DQ_W-1:0] dq_s2_r;

  // two flops on every pin before any logic looks at it
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dqs_s1_r <= 1'b0;
      dqs_s2_r <= 1'b0;
      dqs_s3_r <= 1'b0;
      dq_s1_r  <= {DQ_W{1'b0}};
      dq_s2_r  <= {DQ_W{1'b0}};
    end else begin
      dqs_s1_r <= dqs_pin;
      dqs_s2_r <= dqs_s1_r;
      dqs_s3_r <= dqs_s2_r;
      dq_s1_r  <= dq_pin;
      dq_s2_r  <= dq_s1_r;
    end
  end

  wire strobe_edge = listen && (dqs_s2_r != dqs_s3_r);

  // ----------------------------------------------------------------
  // phase shift: fraction of the measured half period
  // ----------------------------------------------------------------
  reg  [CNT_W-1:0] since_r;
  reg  [CNT_W-1:0] half_r;
  reg  [CNT_W-1:0] dly_r;
  reg              armed_r;
  reg              rise_r;
  reg              have_rise_r;

  wire [7:0]  shift_deg = fcram_mode ? `DSC_SHIFT_FCRAM_DEG : `DSC_SHIFT_DDR_DEG; // R5
  wire [15:0] prod      = half_r * shift_deg;
  wire [15:0] quot      = prod / `DSC_HALF_CYCLE_DEG;
  wire [CNT_W-1:0] tgt  = quot[CNT_W-1:0];
  wire        fire      = armed_r && (dly_r >= tgt); // R5

  // measure edge spacing, then delay each edge to mid-window (90 degrees) for ddr, 72 degrees for fcram
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      since_r      <= {CNT_W{1'b0}};
      half_r       <= {CNT_W{1'b0}};
      dly_r        <= {CNT_W{1'b0}};
      armed_r      <= 1'b0;
      rise_r       <= 1'b0;
      have_rise_r  <= 1'b0;
      pair_valid_r <= 1'b0;
      pair_data_r  <= {2*DQ_W{1'b0}};
    end else begin
      pair_valid_r <= 1'b0;
      // since_r saturates at all ones, so half_r = since_r + 1 wraps to zero on the first edge after an idle strobe
      if (strobe_edge) begin
        since_r <= {CNT_W{1'b0}};
        half_r  <= since_r + 1'b1;
        dly_r   <= {CNT_W{1'b0}};
        armed_r <= 1'b1;
        rise_r  <= dqs_s2_r;
      end else begin
        if (since_r != {CNT_W{1'b1}}) begin
          since_r <= since_r + 1'b1;
        end
        if (armed_r) begin
          dly_r <= dly_r + 1'b1;
        end
      end
      // shifted strobe samples data on both edges
      if (fire && !strobe_edge) begin
        armed_r <= 1'b0;
        if (rise_r) begin
          pair_data_r[DQ_W-1:0] <= dq_s2_r; // R11
          have_rise_r           <= 1'b1;
        end else if (have_rise_r) begin
          pair_data_r[2*DQ_W-1:DQ_W] <= dq_s2_r; // R11
          have_rise_r                <= 1'b0;
          pair_valid_r               <= 1'b1; // R11
        end
      end
      if (!listen) begin
        have_rise_r <= 1'b0;
      end
    end
  end

endmodule // dsc_edge_cap

`default_nettype wire

// file: logic/dsc_fifo.v
// flop-based fifo with a registered output stage
`timescale 1ns/1ps
`default_nettype none

module dsc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             resetn,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output reg              out_valid_r,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_r
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;

  wire push = in_valid && in_ready;
  wire pop  = (count_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready);

  // full only when every entry holds data
  assign in_ready = (count_r != DEPTH[AW:0]);

  // storage written by index, no reset needed on data
  always @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers, fill level and output stage
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      count_r     <= {(AW+1){1'b0}};
      out_valid_r <= 1'b0;
      out_data_r  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r    <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
        out_data_r  <= mem_r[rd_ptr_r];
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // dsc_fifo

`default_nettype wire

// file: logic/dsc_regs.vh
// constants for the strobe-capture ddr datapath
`ifndef DSC_REGS_VH
`define DSC_REGS_VH

// ----------------------------------------------------------------
// group layout
// ----------------------------------------------------------------
`define DSC_DQ_PER_GROUP   8
`define DSC_DM_PER_GROUP   1
`define DSC_NUM_GROUPS     8
`define DSC_WORDS_PER_CYC  2

// ----------------------------------------------------------------
// strobe phase shift, degrees
// ----------------------------------------------------------------
`define DSC_SHIFT_DDR_DEG   8'd90
`define DSC_SHIFT_FCRAM_DEG 8'd72
`define DSC_HALF_CYCLE_DEG  16'd180

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DSC_SYS_MHZ        250
`define DSC_LINK_MHZ       133
// quarter link period in sys clocks, rounded down, at least one
`define DSC_WR_QTR_RAW     (`DSC_SYS_MHZ / (4 * `DSC_LINK_MHZ))
`define DSC_WR_QTR_CYC     ((`DSC_WR_QTR_RAW > 0) ? `DSC_WR_QTR_RAW : 1)
`define DSC_FIFO_DEPTH     8

`endif

// file: logic/dsc_top.v
// ddr strobe-capture datapath: read capture, resync fifo, write launch
// Function
// R1 - each group is one strobe pin, eight data pins and one mask pin
// R2 - a group's strobe times capture of its own eight data bits only
// R3 - data bus width per strobe is by-8 in every bank
// R4 - up to eight strobe/data groups in total
// R5 - strobe delayed 90 degrees for ddr, 72 for fcram, centred in window
// R6 - shifted strobe is distributed as a global capture enable
// R7 - shifted strobe clocks the logic_cell capture registers of its group; here sys_clk clocks them and the shifted strobe only enables the load
// R8 - data and output-enable launch on a phase-shifted clock from a divider; here they launch on sys_clk, paced by a quarter-period enable from a divider
// R9 - captured data resynchronised to core clock through a fifo
// R10 - datapath sized to run the link at 133 mhz; quarter clamps to one sys clock, so writes run the link at 62.5 mhz
// R11 - data sampled on both strobe edges, two words per strobe cycle
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.vh"

module dsc_top #(
  parameter NUM_GROUPS = `DSC_NUM_GROUPS,   // R4
  parameter DQ_W       = `DSC_DQ_PER_GROUP, // R3
  parameter FIFO_DEPTH = `DSC_FIFO_DEPTH,
  parameter FIFO_AW    = 3,
  parameter QTR_CYC    = `DSC_WR_QTR_CYC    // R10
) (
  // clock and reset
  input  wire                          sys_clk,
  input  wire                          resetn,
  // mode pin, raw
  input  wire                          fcram_mode_pin,
  // memory strobes, two-way
  input  wire [NUM_GROUPS-1:0]         dqs_in,
  output reg  [NUM_GROUPS-1:0]         dqs_out_r,
  output reg  [NUM_GROUPS-1:0]         dqs_oe_n_r,
  // memory data, two-way
  input  wire [NUM_GROUPS*DQ_W-1:0]    dq_in,
  output reg  [NUM_GROUPS*DQ_W-1:0]    dq_out_r,
  output reg  [NUM_GROUPS*DQ_W-1:0]    dq_oe_n_r,
  // memory data mask
  output reg  [NUM_GROUPS-1:0]         dm_out_r,
  // read words to the core
  output wire                          rd_valid,
  input  wire                          rd_ready,
  output wire [NUM_GROUPS*2*DQ_W-1:0]  rd_data,
  output reg                           rd_overrun_r,
  // write words from the core
  input  wire                          wr_valid,
  output reg                           wr_ready_r,
  input  wire [NUM_GROUPS*2*DQ_W-1:0]  wr_data,
  input  wire [NUM_GROUPS*2-1:0]       wr_mask,
  output reg                           wr_busy_r
);

  localparam WORD_W = 2 * DQ_W;
  localparam BUS_W  = NUM_GROUPS * WORD_W;

  // write sequencer states
  localparam [1:0] WS_IDLE  = 2'b00;
  localparam [1:0] WS_RISE  = 2'b01;
  localparam [1:0] WS_FALL  = 2'b10;
  localparam [1:0] WS_POST  = 2'b11;

  // ----------------------------------------------------------------
  // mode pin synchroniser
  // ----------------------------------------------------------------
  reg fcram_s1_r;
  reg fcram_s2_r;

  // mode is static in use; two flops keep it metastability-clean
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fcram_s1_r <= 1'b0;
      fcram_s2_r <= 1'b0;
    end else begin
      fcram_s1_r <= fcram_mode_pin;
      fcram_s2_r <= fcram_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // read capture per group
  // ----------------------------------------------------------------
  wire [NUM_GROUPS-1:0] pair_valid;
  wire [BUS_W-1:0]      pair_data;
  reg  [NUM_GROUPS-1:0] held_r;
  reg  [BUS_W-1:0]      held_data_r;
  reg                   listen_r;
  // declared ahead of the per-group stages, which read push_all
  wire                  fifo_in_ready;
  wire                  push_all = (&held_r) && fifo_in_ready;

  // one strobe per eight data lines, no cross-group use
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g = g + 1) begin : g_grp
      dsc_edge_cap #(
        .DQ_W  (DQ_W),
        .CNT_W (8)
      ) u_cap (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .dqs_pin      (dqs_in[g]),                 // R2
        .dq_pin       (dq_in[g*DQ_W +: DQ_W]),     // R1
        .listen       (listen_r),
        .fcram_mode   (fcram_s2_r),
        .pair_valid_r (pair_valid[g]),             // R6
        .pair_data_r  (pair_data[g*WORD_W +: WORD_W])
      );

      // logic_cell holding stage, loaded by the shifted strobe enable
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          held_r[g]                        <= 1'b0;
          held_data_r[g*WORD_W +: WORD_W]  <= {WORD_W{1'b0}};
        end else if (pair_valid[g] && (!held_r[g] || push_all)) begin
          held_r[g]                        <= 1'b1;  // R7
          held_data_r[g*WORD_W +: WORD_W]  <= pair_data[g*WORD_W +: WORD_W]; // R7
        end else if (push_all) begin
          held_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // resync fifo toward the core
  // ----------------------------------------------------------------
  // a group that fills while its word is still held has lost data
  wire lost = |(pair_valid & held_r & ~{NUM_GROUPS{push_all}});

  dsc_fifo #(
    .WIDTH (BUS_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .in_valid    (&held_r),           // R9
    .in_ready    (fifo_in_ready),
    .in_data     (held_data_r),       // R9
    .out_valid_r (rd_valid),
    .out_ready   (rd_ready),
    .out_data_r  (rd_data)
  );

  // sticky overrun: the memory cannot be stalled, so report the loss
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_overrun_r <= 1'b0;
    end else if (lost) begin
      rd_overrun_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // launch phase divider
  // ----------------------------------------------------------------
  reg [7:0] qtr_cnt_r;
  wire      qtr_tick = (qtr_cnt_r == QTR_CYC[7:0] - 8'h01);

  // quarter-period enable stands in for the shifted pll clock
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      qtr_cnt_r <= 8'h00;
    end else if (qtr_tick) begin
      qtr_cnt_r <= 8'h00;  // R8
    end else begin
      qtr_cnt_r <= qtr_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // write sequencer
  // ----------------------------------------------------------------
  reg [1:0]              ws_r;
  reg [1:0]              ws_nxt;
  reg                    half_r;
  reg [BUS_W-1:0]        wbuf_r;
  reg [NUM_GROUPS*2-1:0] wmask_r;
  // half-quarter phase as it will stand after this edge; the strobe is
  // launched from it so the first quarter of a word is never stale
  wire                   half_nxt = (ws_r == WS_IDLE && wr_valid && wr_ready_r) ? 1'b0 :
                                    (qtr_tick ? ~half_r : half_r);

  // each word: rise data, strobe up a quarter later, fall data, strobe down
  always @* begin
    ws_nxt = ws_r;
    case (ws_r)
      WS_IDLE: begin
        if (wr_valid && wr_ready_r) begin
          ws_nxt = WS_RISE;
        end
      end
      WS_RISE: begin
        if (qtr_tick && half_r) begin
          ws_nxt = WS_FALL;
        end
      end
      WS_FALL: begin
        if (qtr_tick && half_r) begin
          ws_nxt = WS_POST;
        end
      end
      WS_POST: begin
        if (qtr_tick) begin
          ws_nxt = WS_IDLE;
        end
      end
      default: begin
        ws_nxt = WS_IDLE;
      end
    endcase
  end

  // registered pin drive; enables low while driving
  integer i;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ws_r       <= WS_IDLE;
      half_r     <= 1'b0;
      wbuf_r     <= {BUS_W{1'b0}};
      wmask_r    <= {(NUM_GROUPS*2){1'b0}};
      wr_ready_r <= 1'b0;
      wr_busy_r  <= 1'b0;
      listen_r   <= 1'b0;
      dqs_out_r  <= {NUM_GROUPS{1'b0}};
      dqs_oe_n_r <= {NUM_GROUPS{1'b1}};
      dq_out_r   <= {(NUM_GROUPS*DQ_W){1'b0}};
      dq_oe_n_r  <= {(NUM_GROUPS*DQ_W){1'b1}};
      dm_out_r   <= {NUM_GROUPS{1'b0}};
    end else begin
      ws_r       <= ws_nxt;
      wr_ready_r <= (ws_nxt == WS_IDLE) && !(wr_valid && wr_ready_r);
      wr_busy_r  <= (ws_nxt != WS_IDLE);
      // capture only while the pins are not ours
      listen_r   <= (ws_nxt == WS_IDLE);
      if (ws_r == WS_IDLE && wr_valid && wr_ready_r) begin
        wbuf_r  <= wr_data;
        wmask_r <= wr_mask;
        half_r  <= 1'b0;
      end else if (qtr_tick) begin
        half_r <= ~half_r;
      end
      // output and output-enable launched on sys_clk, paced by the quarter-period enable
      for (i = 0; i < NUM_GROUPS; i = i + 1) begin
        case (ws_nxt)
          WS_RISE: begin
            dq_out_r[i*DQ_W +: DQ_W]  <= wbuf_r[i*WORD_W +: DQ_W];      // R8
            dq_oe_n_r[i*DQ_W +: DQ_W] <= {DQ_W{1'b0}};                  // R8
            dm_out_r[i]               <= wmask_r[2*i];
            dqs_oe_n_r[i]             <= 1'b0;
            dqs_out_r[i]              <= half_nxt;
          end
          WS_FALL: begin
            dq_out_r[i*DQ_W +: DQ_W]  <= wbuf_r[i*WORD_W+DQ_W +: DQ_W]; // R8
            dq_oe_n_r[i*DQ_W +: DQ_W] <= {DQ_W{1'b0}};
            dm_out_r[i]               <= wmask_r[2*i+1];
            dqs_oe_n_r[i]             <= 1'b0;
            dqs_out_r[i]              <= ~half_nxt;
          end
          WS_POST: begin
            // strobe held low one quarter so the last edge settles
            dq_oe_n_r[i*DQ_W +: DQ_W] <= {DQ_W{1'b1}};
            dqs_oe_n_r[i]             <= 1'b0;
            dqs_out_r[i]              <= 1'b0;
          end
          default: begin
            dq_oe_n_r[i*DQ_W +: DQ_W] <= {DQ_W{1'b1}};
            dqs_oe_n_r[i]             <= 1'b1;
            dqs_out_r[i]              <= 1'b0;
            dm_out_r[i]               <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // dsc_top

`default_nettype wire

// file: tb/dsc_mem_model.sv
// behavioural memory: edge-aligned read bursts, write byte capture
`timescale 1ns/1ps
`default_nettype none
module dsc_mem_model #(
  parameter G = 8
) (
  // pins from the datapath
  input  wire logic           sys_clk,
  input  wire logic [G-1:0]   dqs_o,
  input  wire logic [G-1:0]   dqs_oe_n,
  input  wire logic [8*G-1:0] dq_o,
  input  wire logic [G-1:0]   dm_o,
  // memory drive
  output var  logic [G-1:0]   dqs_m,
  output var  logic [8*G-1:0] dq_m
);
  logic [16*G-1:0] rd_word [0:15];
  logic [16*G-1:0] wr_cap;
  logic [2*G-1:0]  wm_cap;
  logic [G-1:0]    dqs_q;
  initial begin
    dqs_m = '0;
    dq_m = '0;
  end
  // one dummy cycle leads, since the first pair after idle is unreliable
  task automatic burst(input int n);
    logic [16*G-1:0] w;
    #1.3;
    for (int k = -1; k < n; k++) begin
      w = (k < 0) ? ~rd_word[0] : rd_word[k];
      for (int g = 0; g < G; g++) dq_m[8*g+:8] = w[16*g+:8];
      dqs_m = '1;
      #80;
      for (int g = 0; g < G; g++) dq_m[8*g+:8] = w[16*g+8+:8];
      dqs_m = '0;
      #80;
    end
    dq_m = ~dq_m; // released bus: no stale value
  endtask
  // write capture on the strobe edges of each group
  always @(posedge sys_clk) begin
    dqs_q <= dqs_o;
    for (int g = 0; g < G; g++) begin
      if (!dqs_oe_n[g] && dqs_o[g] && !dqs_q[g]) begin
        wr_cap[16*g+:8] <= dq_o[8*g+:8];
        wm_cap[2*g] <= dm_o[g];
      end
      if (!dqs_oe_n[g] && !dqs_o[g] && dqs_q[g]) begin
        wr_cap[16*g+8+:8] <= dq_o[8*g+:8];
        wm_cap[2*g+1] <= dm_o[g];
      end
    end
  end
endmodule // dsc_mem_model
`default_nettype wire

// file: tb/dsc_top_props.sv
// concurrent checks on the ports of the strobe-capture datapath
`timescale 1ns/1ps
`default_nettype none
module dsc_top_props #(
  parameter NUM_GROUPS = 8,
  parameter DQ_W       = 8
) (
  input wire logic                         sys_clk,
  input wire logic                         resetn,
  input wire logic                         fcram_mode_pin,
  input wire logic [NUM_GROUPS-1:0]        dqs_in,
  input wire logic [NUM_GROUPS-1:0]        dqs_out_r,
  input wire logic [NUM_GROUPS-1:0]        dqs_oe_n_r,
  input wire logic [NUM_GROUPS*DQ_W-1:0]   dq_in,
  input wire logic [NUM_GROUPS*DQ_W-1:0]   dq_out_r,
  input wire logic [NUM_GROUPS*DQ_W-1:0]   dq_oe_n_r,
  input wire logic [NUM_GROUPS-1:0]        dm_out_r,
  input wire logic                         rd_valid,
  input wire logic                         rd_ready,
  input wire logic [NUM_GROUPS*2*DQ_W-1:0] rd_data,
  input wire logic                         rd_overrun_r,
  input wire logic                         wr_valid,
  input wire logic                         wr_ready_r,
  input wire logic [NUM_GROUPS*2*DQ_W-1:0] wr_data,
  input wire logic [NUM_GROUPS*2-1:0]      wr_mask,
  input wire logic                         wr_busy_r
);
  // ----------------------------------------------------------------
  // properties; write timing assumes one sys clock per quarter
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_reset_idle;
    $rose(resetn) |-> (&dqs_oe_n_r) && (&dq_oe_n_r) && !rd_valid && !wr_busy_r;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
  property p_accept;
    wr_valid && wr_ready_r |=> wr_busy_r && !wr_ready_r;
  endproperty
  a_accept: assert property (p_accept) else $error("write accept not followed by busy");
  property p_release;
    !wr_busy_r |-> (&dq_oe_n_r) && (&dqs_oe_n_r);
  endproperty
  a_release: assert property (p_release) else $error("pins driven while idle");
  property p_group_oe;
    (&dq_oe_n_r == |dq_oe_n_r) && (&dqs_oe_n_r == |dqs_oe_n_r) &&
    (dq_oe_n_r[0] || !dqs_oe_n_r[0]);
  endproperty
  a_group_oe: assert property (p_group_oe) else $error("group enables disagree");
  property p_strobe_shape;
    $fell(dqs_oe_n_r[0]) |-> (dqs_out_r == '0) ##1 (dqs_out_r == '1) ##2 (dqs_out_r == '0);
  endproperty
  a_strobe_shape: assert property (p_strobe_shape) else $error("write strobe shape wrong");
  property p_drive_len;
    $fell(dqs_oe_n_r[0]) |-> (!dqs_oe_n_r[0]) [*5] ##1 dqs_oe_n_r[0];
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("write drive length wrong");
  property p_ready_back;
    $rose(dqs_oe_n_r[0]) |-> ##[0:2] wr_ready_r;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready not restored");
  property p_rd_hold;
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read word dropped before taken");
  c_write: cover property (wr_valid && wr_ready_r);
  c_overrun: cover property ($rose(rd_overrun_r));
  c_take: cover property (rd_valid && rd_ready);
endmodule // dsc_top_props
bind dsc_top dsc_top_props #(.NUM_GROUPS(NUM_GROUPS), .DQ_W(DQ_W)) u_props (
  .sys_clk(sys_clk), .resetn(resetn), .fcram_mode_pin(fcram_mode_pin),
  .dqs_in(dqs_in), .dqs_out_r(dqs_out_r), .dqs_oe_n_r(dqs_oe_n_r),
  .dq_in(dq_in), .dq_out_r(dq_out_r), .dq_oe_n_r(dq_oe_n_r), .dm_out_r(dm_out_r),
  .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
  .rd_overrun_r(rd_overrun_r), .wr_valid(wr_valid), .wr_ready_r(wr_ready_r),
  .wr_data(wr_data), .wr_mask(wr_mask), .wr_busy_r(wr_busy_r));
`default_nettype wire

// file: tb/tb_dsc_top.sv
// testbench for the strobe-capture datapath
`timescale 1ns/1ps
`default_nettype none
module tb_dsc_top;
  localparam int G = 8;
  logic            sys_clk, resetn, fcram_mode_pin, rd_ready, wr_valid;
  logic            rd_valid, rd_overrun_r, wr_ready_r, wr_busy_r;
  logic [G-1:0]    dqs_out_r, dqs_oe_n_r, dm_out_r, dqs_m, dqs_in;
  logic [8*G-1:0]  dq_out_r, dq_oe_n_r, dq_m, dq_in;
  logic [16*G-1:0] rd_data, wr_data;
  logic [2*G-1:0]  wr_mask;
  logic [16*G-1:0] q [$];
  int              miscompares, checked, cycles;
  // ----------------------------------------------------------------
  // pins resolved from both parties' drives
  // ----------------------------------------------------------------
  assign dqs_in = (~dqs_oe_n_r & dqs_out_r) | (dqs_oe_n_r & dqs_m);
  assign dq_in = (~dq_oe_n_r & dq_out_r) | (dq_oe_n_r & dq_m);
  dsc_top #(.NUM_GROUPS(G)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .fcram_mode_pin(fcram_mode_pin),
    .dqs_in(dqs_in), .dqs_out_r(dqs_out_r), .dqs_oe_n_r(dqs_oe_n_r),
    .dq_in(dq_in), .dq_out_r(dq_out_r), .dq_oe_n_r(dq_oe_n_r), .dm_out_r(dm_out_r),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_overrun_r(rd_overrun_r), .wr_valid(wr_valid), .wr_ready_r(wr_ready_r),
    .wr_data(wr_data), .wr_mask(wr_mask), .wr_busy_r(wr_busy_r));
  dsc_mem_model #(.G(G)) mem (
    .sys_clk(sys_clk), .dqs_o(dqs_out_r), .dqs_oe_n(dqs_oe_n_r), .dq_o(dq_out_r),
    .dm_o(dm_out_r), .dqs_m(dqs_m), .dq_m(dq_m));
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  // hang guard, far above the roughly 1600 cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // take words until the fifo stays empty for a while
  task automatic drain();
    int idle;
    idle = 0;
    q.delete();
    @(negedge sys_clk) rd_ready = 1;
    while (idle < 100) begin
      @(posedge sys_clk);
      if (rd_valid === 1'b1) begin
        q.push_back(rd_data);
        idle = 0;
      end else idle++;
    end
    @(negedge sys_clk) rd_ready = 0;
  endtask
  // words with distinct bytes per group so swapped groups show up
  task automatic fill_words(input int n, input logic [7:0] base);
    for (int k = 0; k < n; k++)
      for (int g = 0; g < G; g++)
        mem.rd_word[k][16*g+:16] = {8'(base + 8'h80 + 16*k + g), 8'(base + 16*k + g)};
  endtask
  task automatic sc_read(input logic mode);
    @(negedge sys_clk) fcram_mode_pin = mode;
    repeat (4) @(negedge sys_clk);
    fill_words(4, {mode, 7'h05});
    mem.burst(4);
    drain();
    chk(q.size() >= 4, 1);
    if (q.size() >= 4)
      for (int k = 0; k < 4; k++) chk(q[q.size()-4+k], mem.rd_word[k]);
    chk(rd_valid, 0);
  endtask
  task automatic sc_fill();
    fill_words(12, 8'h33);
    mem.burst(12);
    chk(rd_valid, 1);
    chk(rd_overrun_r, 1);
    drain();
    chk(q.size() < 13, 1);
    chk(q.size() > 7, 1);
    chk(rd_valid, 0);
    @(negedge sys_clk) resetn = 0;
    @(negedge sys_clk);
    chk(rd_overrun_r, 0);
    chk(&{dqs_oe_n_r, dq_oe_n_r}, 1);
    resetn = 1;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [127:0] w, input logic [15:0] m);
    int n;
    n = 0;
    @(negedge sys_clk);
    wr_valid = 1;
    wr_data = w;
    wr_mask = m;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wr_ready_r !== 1'b1 && n < 50);
    @(negedge sys_clk) wr_valid = 0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wr_busy_r !== 1'b0 && n < 50);
    @(negedge sys_clk);
    chk(mem.wr_cap, w);
    chk(mem.wm_cap, m);
  endtask
  task automatic summarize();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    resetn = 0;
    fcram_mode_pin = 0;
    rd_ready = 0;
    wr_valid = 0;
    wr_data = '0;
    wr_mask = '0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1;
    repeat (2) @(negedge sys_clk);
    sc_read(0);
    sc_read(1);
    wr(128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0, 16'h5a3c);
    wr(128'hfedcba98765432100123456789abcdef, 16'ha5c3);
    sc_fill();
    sc_read(0);
    summarize();
  end
endmodule // tb_dsc_top
`default_nettype wire
